/* File: hdl/tsmc_top.sv */
// timer slave-mode controller with axi4-lite registers
//
// Added by the designer: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module tsmc_top #(
	parameter int CNT_W = 16
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic [7:0]       s_axi_awaddr,
	input  wire logic             s_axi_awvalid,
	output logic                  s_axi_awready,
	input  wire logic [31:0]      s_axi_wdata,
	input  wire logic [3:0]       s_axi_wstrb,
	input  wire logic             s_axi_wvalid,
	output logic                  s_axi_wready,
	output logic [1:0]            s_axi_bresp,
	output logic                  s_axi_bvalid,
	input  wire logic             s_axi_bready,
	input  wire logic [7:0]       s_axi_araddr,
	input  wire logic             s_axi_arvalid,
	output logic                  s_axi_arready,
	output logic [31:0]           s_axi_rdata,
	output logic [1:0]            s_axi_rresp,
	output logic                  s_axi_rvalid,
	input  wire logic             s_axi_rready,
	input  wire logic             rc_osc_sel,
	input  wire logic             ext_trig_pin,
	input  wire logic             ch1_pin,
	input  wire logic             ch2_pin,
	input  wire logic             internal_trigger_zero,
	output logic                  trigger_out,
	output logic [CNT_W-1:0]      count
);
	// ======================================
	// registers
	logic [31:0] slave_mode_control;
	logic        counter_enable_bit;
	logic [2:0]  slave_mode_sel;
	logic [2:0]  trigger_source_sel;
	logic        master_slave_sync;
	logic [3:0]  ext_trig_filter_sel;
	logic [1:0]  ext_trig_psc_sel;
	logic        ext_trig_pol;
	logic        trig_rise;
	logic        trig_level;
	logic        cnt_dir;
	logic        ext_trig_filtered;
	assign slave_mode_sel      = slave_mode_control[tsmc_pkg::SMS_LO +: 3];
	assign trigger_source_sel  = slave_mode_control[tsmc_pkg::TS_LO +: 3];
	assign master_slave_sync   = slave_mode_control[tsmc_pkg::MSM_BIT];
	assign ext_trig_filter_sel = slave_mode_control[tsmc_pkg::ETF_LO +: 4];
	assign ext_trig_psc_sel    = slave_mode_control[tsmc_pkg::ETPS_LO +: 2];
	assign ext_trig_pol        = slave_mode_control[tsmc_pkg::ETP_BIT];

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		return r;
	endfunction : merge

	// ======================================
	// axi4-lite write
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        do_write;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign do_write      = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= tsmc_pkg::RESP_OKAY;
		end
		else if (do_write)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (aw_addr == tsmc_pkg::ADDR_SMCR ||
				aw_addr == tsmc_pkg::ADDR_CTRL) ?
				tsmc_pkg::RESP_OKAY : tsmc_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			slave_mode_control <= tsmc_pkg::SMCR_RESET;
			counter_enable_bit <= 1'b0;
		end
		else
		begin
			if (do_write && aw_addr == tsmc_pkg::ADDR_SMCR)
				slave_mode_control <= merge(slave_mode_control, w_data,
					w_strb) & tsmc_pkg::SMCR_MASK;
			if (do_write && aw_addr == tsmc_pkg::ADDR_CTRL && w_strb[0])
				counter_enable_bit <= w_data[tsmc_pkg::CEN_BIT];
			if (slave_mode_sel == tsmc_pkg::TSMC_SM_TRIG && trig_rise)
				counter_enable_bit <= 1'b1;
		end
	end

	// ======================================
	// axi4-lite read
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= tsmc_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= tsmc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				tsmc_pkg::ADDR_SMCR:
					s_axi_rdata <= slave_mode_control;
				tsmc_pkg::ADDR_CTRL:
					s_axi_rdata <= {31'h0, counter_enable_bit};
				tsmc_pkg::ADDR_STATUS:
					s_axi_rdata <= {29'h0, cnt_dir, trig_level,
						ext_trig_filtered};
				tsmc_pkg::ADDR_COUNT:
					s_axi_rdata <= 32'(count);
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= tsmc_pkg::RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ======================================
	// pin synchronisers
	logic [1:0] etr_s;
	logic [1:0] ch1_s;
	logic [1:0] ch2_s;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			etr_s <= 2'b00;
			ch1_s <= 2'b00;
			ch2_s <= 2'b00;
		end
		else
		begin
			etr_s <= {etr_s[0], ext_trig_pin};
			ch1_s <= {ch1_s[0], ch1_pin};
			ch2_s <= {ch2_s[0], ch2_pin};
		end
	end
	logic ch1_filtered_input;
	logic ch2_filtered_input;
	assign ch1_filtered_input = ch1_s[1];
	assign ch2_filtered_input = ch2_s[1];

	// ======================================
	// external trigger polarity and prescaler
	logic       etr_pol;
	logic       etr_pol_d;
	logic [2:0] psc_cnt;
	logic       ext_trig_prescaled;
	assign etr_pol = etr_s[1] ^ ext_trig_pol;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			etr_pol_d          <= 1'b0;
			psc_cnt            <= 3'h0;
			ext_trig_prescaled <= 1'b0;
		end
		else
		begin
			etr_pol_d <= etr_pol;
			if (ext_trig_psc_sel == 2'b00)
				ext_trig_prescaled <= etr_pol;
			else if (etr_pol && !etr_pol_d)
			begin
				psc_cnt <= psc_cnt + 3'h1;
				// toggle output every 2^(psc-1) rising edges
				if ((psc_cnt & ((3'h1 << (ext_trig_psc_sel - 2'h1)) - 3'h1))
					== ((3'h1 << (ext_trig_psc_sel - 2'h1)) - 3'h1))
					ext_trig_prescaled <= !ext_trig_prescaled;
			end
		end
	end

	// ======================================
	// external trigger filter
	logic [5:0] fdiv;
	logic [3:0] fn;
	logic [5:0] pclk_div;
	logic [5:0] pclk_cnt;
	logic       pclk_tick;
	logic [5:0] samp_cnt;
	logic [3:0] agree_cnt;
	always_comb
	begin
		case (ext_trig_filter_sel)
			4'h0: begin fdiv = 6'd1; fn = 4'd1; end
			4'h1: begin fdiv = 6'd1; fn = 4'd2; end
			4'h2: begin fdiv = 6'd1; fn = 4'd4; end
			4'h3: begin fdiv = 6'd1; fn = 4'd8; end
			4'h4: begin fdiv = 6'd2; fn = 4'd6; end
			4'h5: begin fdiv = 6'd2; fn = 4'd8; end
			4'h6: begin fdiv = 6'd4; fn = 4'd6; end
			4'h7: begin fdiv = 6'd4; fn = 4'd8; end
			4'h8: begin fdiv = 6'd8; fn = 4'd6; end
			4'h9: begin fdiv = 6'd8; fn = 4'd8; end
			4'ha: begin fdiv = 6'd16; fn = 4'd5; end
			4'hb: begin fdiv = 6'd16; fn = 4'd6; end
			4'hc: begin fdiv = 6'd16; fn = 4'd8; end
			4'hd: begin fdiv = 6'd32; fn = 4'd5; end
			4'he: begin fdiv = 6'd32; fn = 4'd6; end
			default: begin fdiv = 6'd32; fn = 4'd8; end
		endcase
	end
	// peripheral clock tick from system clock
	assign pclk_div = rc_osc_sel ? 6'(tsmc_pkg::PCLK_DIV_RC) :
		6'(tsmc_pkg::PCLK_DIV_XTAL);
	assign pclk_tick = (pclk_cnt >= pclk_div - 6'd1);
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pclk_cnt  <= 6'h00;
			samp_cnt  <= 6'h00;
			agree_cnt <= 4'h0;
			ext_trig_filtered <= 1'b0;
		end
		else
		begin
			pclk_cnt <= pclk_tick ? 6'h00 : pclk_cnt + 6'h01;
			if (pclk_tick)
			begin
				samp_cnt <= (samp_cnt >= fdiv - 6'd1) ? 6'h00 :
					samp_cnt + 6'h01;
				if (samp_cnt >= fdiv - 6'd1)
				begin
					if (ext_trig_prescaled == ext_trig_filtered)
						agree_cnt <= 4'h0;
					else if (agree_cnt + 4'h1 >= fn)
					begin
						ext_trig_filtered <= ext_trig_prescaled;
						agree_cnt <= 4'h0;
					end
					else
						agree_cnt <= agree_cnt + 4'h1;
				end
			end
		end
	end

	// ======================================
	// trigger selection, edge detect, sync delay
	logic ch1_d;
	logic ch1_edge_detect;
	logic trig_sel;
	logic trig_d1;
	logic trigger_in;
	logic trig_prev;
	assign ch1_edge_detect = ch1_filtered_input ^ ch1_d;
	always_comb
	begin
		case (trigger_source_sel)
			tsmc_pkg::TS_INT_TRIG0: trig_sel = internal_trigger_zero;
			tsmc_pkg::TS_TI1ED: trig_sel = ch1_edge_detect;
			tsmc_pkg::TS_TI1:   trig_sel = ch1_filtered_input;
			tsmc_pkg::TS_TI2:   trig_sel = ch2_filtered_input;
			tsmc_pkg::TS_EXT_TRIG: trig_sel = ext_trig_filtered;
			default:            trig_sel = 1'b0;
		endcase
	end
	assign trigger_in = master_slave_sync ? trig_d1 : trig_sel;
	assign trig_rise  = trigger_in && !trig_prev;
	assign trig_level = trigger_in;
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ch1_d     <= 1'b0;
			trig_d1   <= 1'b0;
			trig_prev <= 1'b0;
		end
		else
		begin
			ch1_d     <= ch1_filtered_input;
			trig_d1   <= trig_sel;
			trig_prev <= trigger_in;
		end
	end

	// ======================================
	// slave mode counter control
	logic ch2_d;
	logic cnt_step;
	logic cnt_clear;
	always_comb
	begin
		cnt_step  = 1'b0;
		cnt_dir   = 1'b0;
		cnt_clear = 1'b0;
		case (slave_mode_sel)
			tsmc_pkg::TSMC_SM_OFF:
				cnt_step = counter_enable_bit;
			tsmc_pkg::TSMC_SM_ENC1:
			begin
				cnt_step = ch1_filtered_input ^ ch1_d;
				cnt_dir  = ch1_filtered_input == ch2_filtered_input;
			end
			tsmc_pkg::TSMC_SM_ENC2:
			begin
				cnt_step = ch2_filtered_input ^ ch2_d;
				cnt_dir  = ch1_filtered_input != ch2_filtered_input;
			end
			tsmc_pkg::TSMC_SM_ENC3:
			begin
				cnt_step = (ch1_filtered_input ^ ch1_d) ^
					(ch2_filtered_input ^ ch2_d);
				cnt_dir  = (ch1_filtered_input ^ ch1_d) ?
					ch1_filtered_input == ch2_filtered_input :
					ch1_filtered_input != ch2_filtered_input;
			end
			tsmc_pkg::TSMC_SM_RESET:
			begin
				cnt_step  = counter_enable_bit;
				cnt_clear = trig_rise;
			end
			tsmc_pkg::TSMC_SM_GATED:
				cnt_step = counter_enable_bit && trigger_in;
			tsmc_pkg::TSMC_SM_TRIG:
				cnt_step = counter_enable_bit;
			tsmc_pkg::TSMC_SM_EXT1:
				cnt_step = trig_rise;
			default:
				cnt_step = 1'b0;
		endcase
	end
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ch2_d       <= 1'b0;
			count       <= '0;
			trigger_out <= 1'b0;
		end
		else
		begin
			ch2_d       <= ch2_filtered_input;
			trigger_out <= cnt_clear;
			if (cnt_clear)
				count <= '0;
			else if (cnt_step)
				count <= cnt_dir ? count - 1'b1 : count + 1'b1;
		end
	end
endmodule : tsmc_top

/* File: hdl/tsmc_pkg.sv */
// constants of the timer slave-mode controller
// Summary of operation
// - trigger filter counts N agreeing samples
// - code 0000 samples every clock, unfiltered
// - code 0001 needs two agreeing samples
// - codes 1011/1100 sample /16, N six/eight
// - codes 1101..1111 sample /32, N 5/6/8
// - sample clock from peripheral clock rate
// - sync bit delays trigger effect
// - source 000 internal trigger, 100 edge detect
// - sources 101/110/111 ch1, ch2, ext trigger
// - external trigger edge follows polarity bit
// - mode 000 counts internal clock when enabled
// - modes 001/010 encoder on one channel
// - mode 011 encoder on both channels
// - mode 100 trigger rise resets counter
// - mode 101 counts while trigger high
// - mode 110 trigger rise starts counter
// - mode 111 trigger rises clock counter
// - edge detector pulses on each ch1 transition
// - filter input is polarity plus prescaler
package tsmc_pkg;
	// ======================================
	// register map
	localparam logic [7:0]  ADDR_SMCR   = 8'h08;
	localparam logic [7:0]  ADDR_CTRL   = 8'h00;
	localparam logic [7:0]  ADDR_STATUS = 8'h04;
	localparam logic [7:0]  ADDR_COUNT  = 8'h0c;
	localparam logic [31:0] SMCR_RESET  = 32'h0000_0000;
	localparam logic [31:0] SMCR_MASK   = 32'h0000_fff7;
	localparam int SMS_LO = 0;
	localparam int TS_LO  = 4;
	localparam int MSM_BIT = 7;
	localparam int ETF_LO = 8;
	localparam int ETPS_LO = 12;
	localparam int ETP_BIT = 15;
	localparam int CEN_BIT = 0;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ======================================
	// slave modes and trigger sources
	typedef enum logic [2:0] {
		TSMC_SM_OFF, TSMC_SM_ENC1, TSMC_SM_ENC2, TSMC_SM_ENC3,
		TSMC_SM_RESET, TSMC_SM_GATED, TSMC_SM_TRIG, TSMC_SM_EXT1
	} tsmc_mode_t;
	localparam logic [2:0] TS_INT_TRIG0 = 3'h0;
	localparam logic [2:0] TS_TI1ED = 3'h4;
	localparam logic [2:0] TS_TI1 = 3'h5;
	localparam logic [2:0] TS_TI2 = 3'h6;
	localparam logic [2:0] TS_EXT_TRIG = 3'h7;
	// ======================================
	// timing
	localparam int CLK_MHZ = 250;
	localparam int PCLK_XTAL_MHZ = 12;
	localparam int PCLK_RC_MHZ = 6;
	localparam int PCLK_DIV_XTAL = CLK_MHZ / PCLK_XTAL_MHZ;
	localparam int PCLK_DIV_RC = CLK_MHZ / PCLK_RC_MHZ;
endpackage : tsmc_pkg

/* File: test/tsmc_checker.sv */
// port assertions of the timer slave-mode controller
`timescale 1ns/1ps
module tsmc_checker #(
	parameter int CNT_W = 16
) (
	input wire logic             clk,
	input wire logic             resetn,
	input wire logic             s_axi_awready,
	input wire logic             s_axi_bvalid,
	input wire logic             s_axi_bready,
	input wire logic             s_axi_arvalid,
	input wire logic             s_axi_arready,
	input wire logic [31:0]      s_axi_rdata,
	input wire logic [1:0]       s_axi_rresp,
	input wire logic             s_axi_rvalid,
	input wire logic             s_axi_rready,
	input wire logic             trigger_out,
	input wire logic [CNT_W-1:0] count
);
	// ======================================
	// register bus answers
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence s_r_wait;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid)
		else $error("read not answered next cycle");
	a_read_holds: assert property (s_r_wait |=> s_axi_rvalid
		&& $stable(s_axi_rdata)) else $error("read answer dropped");
	a_write_holds: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid) else $error("write answer dropped");
	a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	a_aw_blocked: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pending");
	a_err_zero: assert property (s_axi_rvalid
		&& s_axi_rresp == tsmc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
		else $error("refused read returns data");
	// ======================================
	// counter
	a_trig_pulse: assert property (trigger_out |=> !trigger_out)
		else $error("reinit pulse longer than one cycle");
	a_count_step: assert property ($changed(count) |-> count == 0
		|| count == CNT_W'($past(count) + 1'b1)
		|| count == CNT_W'($past(count) - 1'b1))
		else $error("counter jumped");
endmodule : tsmc_checker
bind tsmc_top tsmc_checker #(.CNT_W(CNT_W)) tsmc_checker_inst (
	.clk, .resetn, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .trigger_out, .count
);

/* File: test/tsmc_far.sv */
// far-side model: encoder, trigger pin and neighbour timer
`timescale 1ns/1ps
module tsmc_far (
	input  wire logic clk,
	output logic      ext_trig_pin,
	output logic      ch1_pin,
	output logic      ch2_pin,
	output logic      internal_trigger_zero
);
	logic [1:0] ph = 2'h0;
	initial
	begin
		ext_trig_pin = 1'b0;
		internal_trigger_zero = 1'b0;
	end
	// ======================================
	// gray quadrature, ch1 leads going forward
	assign ch1_pin = ph[0] ^ ph[1];
	assign ch2_pin = ph[1];
	task automatic quad(input int n, input logic fwd);
		repeat (n * 4)
		begin
			@(posedge clk);
			ph <= fwd ? ph + 2'h1 : ph - 2'h1;
			repeat (15) @(posedge clk);
		end
	endtask : quad
	task automatic itr(input int n, input int w);
		repeat (n)
		begin
			@(posedge clk);
			internal_trigger_zero <= 1'b1;
			repeat (w) @(posedge clk);
			internal_trigger_zero <= 1'b0;
			repeat (8) @(posedge clk);
		end
	endtask : itr
	task automatic etr(input int n, input int w, input logic idle);
		@(posedge clk);
		ext_trig_pin <= idle;
		repeat (n)
		begin
			@(posedge clk);
			ext_trig_pin <= ~idle;
			repeat (w) @(posedge clk);
			ext_trig_pin <= idle;
			repeat (w + 900) @(posedge clk);
		end
	endtask : etr
endmodule : tsmc_far

/* File: test/tb_tsmc_top.sv */
// self-checking bench of the timer slave-mode controller
`timescale 1ns/1ps
module tb_tsmc_top;
	logic        clk = 1'b0, resetn = 1'b0, rc_osc_sel = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_v, cur = 32'h0;
	logic [3:0]  s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, trigger_out;
	logic        ext_trig_pin, ch1_pin, ch2_pin, internal_trigger_zero;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	logic [15:0] count, c0, cq, d;
	int          n_errors = 0, compares = 0, cyc = 0, t_chg, n_trig = 0;
	int          i, k, m, lt [2];
	int          et [10][5] = '{'{'h77, 0, 3, 30, 3},
		'{'h8077, 0, 3, 30, 3}, '{'h177, 0, 3, 1, 0},
		'{'h177, 0, 3, 50, 3}, '{'h1077, 0, 4, 4, 2},
		'{'hb77, 0, 1, 2200, 1}, '{'hc77, 0, 1, 2200, 0},
		'{'hd77, 0, 1, 4400, 1}, '{'hd77, 1, 1, 4400, 0},
		'{'hf77, 0, 1, 4400, 0}};
	tsmc_top #(.CNT_W(16)) tsmc_top_inst (.clk, .resetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.rc_osc_sel, .ext_trig_pin, .ch1_pin, .ch2_pin,
		.internal_trigger_zero, .trigger_out, .count);
	tsmc_far tsmc_far_inst (.clk, .ext_trig_pin, .ch1_pin, .ch2_pin,
		.internal_trigger_zero);
	initial
	begin
		forever #2 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		cq <= count;
		if (cq != count) t_chg <= cyc;
		if (trigger_out) n_trig <= n_trig + 1;
	end
	// ======================================
	// checks and bus cycles
	task automatic report_and_stop();
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e)
		begin
			$display("FAIL t=%0t got=%h exp=%h", $time, g, e);
			n_errors++;
		end
	endtask : chk
	task automatic fin(input logic is_rd);
		int j;
		for (j = 0; j < 99; j++)
		begin
			@(negedge clk);
			rd_v = s_axi_rdata;
			rsp = is_rd ? s_axi_rresp : s_axi_bresp;
			if (is_rd ? s_axi_rvalid : s_axi_bvalid) break;
		end
		if (j == 99)
		begin
			n_errors++;
			report_and_stop();
		end
		@(posedge clk);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask : fin
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw;
		int   j;
		@(posedge clk);
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (j = 0; j < 99 && !(ta && tw); j++)
		begin
			@(negedge clk);
			ta = ta | s_axi_awready;
			tw = tw | s_axi_wready;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		fin(1'b0);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int j;
		@(posedge clk);
		j = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge clk); while (!s_axi_arready && ++j < 99);
		@(posedge clk);
		s_axi_arvalid <= 1'b0;
		fin(1'b1);
	endtask : rd
	task automatic ctl(input logic [31:0] v);
		wr(tsmc_pkg::ADDR_CTRL, v);
	endtask : ctl
	task automatic sm(input logic [31:0] v);
		wr(tsmc_pkg::ADDR_SMCR, cur & 32'hfffffff8);
		wr(tsmc_pkg::ADDR_SMCR, v & 32'hfffffff8);
		wr(tsmc_pkg::ADDR_SMCR, v);
		cur = v;
	endtask : sm
	// ======================================
	// main sequence
	initial
	begin
		void'($urandom(52));
		repeat (16) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd(tsmc_pkg::ADDR_SMCR);
		chk(rd_v, tsmc_pkg::SMCR_RESET);
		rd(8'h10);
		chk({rd_v[29:0], rsp}, tsmc_pkg::RESP_SLVERR);
		repeat (3)
		begin
			k = $urandom;
			if (k[2:0] == 3'h5)
				k[4] = 1'b1;
			sm(k);
			rd(tsmc_pkg::ADDR_SMCR);
			chk(rd_v, k & tsmc_pkg::SMCR_MASK);
		end
		wr(8'h10, 32'h0);
		chk(rsp, tsmc_pkg::RESP_SLVERR);
		ctl(32'h1);
		chk(rsp, tsmc_pkg::RESP_OKAY);
		sm(32'h4);
		ctl(32'h0);
		k = n_trig;
		tsmc_far_inst.itr(1, 1);
		chk(count, 32'h0);
		chk(n_trig - k, 32'h1);
		for (m = 0; m < 4; m++)
		begin
			sm({m[2:0], 4'h7});
			k = $urandom_range(9, 3);
			c0 = count;
			tsmc_far_inst.itr(k, 1);
			chk(count - c0, m ? 0 : k);
		end
		for (m = 0; m < 2; m++)
		begin
			sm({m[0], 7'h07});
			k = cyc;
			tsmc_far_inst.itr(1, 1);
			lt[m] = t_chg - k;
		end
		chk(lt[1] - lt[0], 32'h1);
		sm(32'h0);
		ctl(32'h1);
		c0 = count;
		repeat (20) @(posedge clk);
		chk(count - c0, 32'h14);
		sm(32'h5);
		c0 = count;
		tsmc_far_inst.itr(1, 30);
		chk(count - c0, 32'h1e);
		c0 = count;
		repeat (20) @(posedge clk);
		chk(count, c0);
		rd(tsmc_pkg::ADDR_COUNT);
		chk(rd_v, 32'(c0));
		ctl(32'h0);
		sm(32'h6);
		tsmc_far_inst.itr(1, 1);
		rd(tsmc_pkg::ADDR_CTRL);
		chk(rd_v[0], 32'h1);
		ctl(32'h0);
		for (m = 1; m < 4; m++)
		begin
			sm(m);
			c0 = count;
			tsmc_far_inst.quad(3, 1'b1);
			d = count - c0;
			chk(d[15] ? -d : d, m == 3 ? 12 : 6);
			tsmc_far_inst.quad(3, 1'b0);
			chk(count, c0);
		end
		for (m = 4; m < 7; m++)
		begin
			sm({m[2:0], 4'h7});
			c0 = count;
			tsmc_far_inst.quad(2, 1'b1);
			chk(count - c0, m == 4 ? 4 : 2);
		end
		for (i = 0; i < 10; i++)
		begin
			rc_osc_sel <= et[i][1][0];
			sm(et[i][0] & 32'hfff8);
			tsmc_far_inst.etr(0, 0, et[i][0][15]);
			repeat (100) @(posedge clk);
			sm(et[i][0]);
			c0 = count;
			tsmc_far_inst.etr(et[i][2], et[i][3], et[i][0][15]);
			chk(count - c0, et[i][4]);
		end
		report_and_stop();
	end
endmodule : tb_tsmc_top
